// ===== ost_outage_timing_unit.sv
`timescale 1ns/100ps
`default_nettype none

module ost_outage_timing_unit #(
  parameter int MS_CYCLES = ost_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Power sense pin, high while supply is good
  input wire logic PWR_GOOD,
  // Power sequence outputs
  output logic PFAIL_INT_N,
  output logic RESTART_HOLD_N,
  output logic RESTART_OUT,
  // Interrupt
  output logic IRQ,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA
);

  // ************************************************************
  // Power sense synchroniser
  // ************************************************************
  logic pg_s1; // First stage, read only by the second
  logic pg_s2;
  logic pg_s3;
  logic pwr_ok; // Accepted supply state
  logic next_pwr_ok;

  // Accept a change once the second and third stages agree
  always_comb begin
    next_pwr_ok = pwr_ok;
    if (pg_s2 == pg_s3) begin
      next_pwr_ok = pg_s3;
    end
  end

  // Register the synchroniser chain
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pg_s1 <= 1'b1;
      pg_s2 <= 1'b1;
      pg_s3 <= 1'b1;
      pwr_ok <= 1'b1;
    end else begin
      pg_s1 <= PWR_GOOD;
      pg_s2 <= pg_s1;
      pg_s3 <= pg_s2;
      pwr_ok <= next_pwr_ok;
    end
  end

  // ************************************************************
  // Time base
  // ************************************************************
  logic ms_tick; // One pulse per millisecond
  logic sec_tick; // One pulse per second, phase restarted at each failure
  logic fail_event; // Cycle in which a failure is seen
  ost_pkg::ost_seq_t seq; // Power sequence state

  assign fail_event = (seq == ost_pkg::SEQ_RUN) && !pwr_ok;

  ost_tick_gen #(
    .MS_CYCLES(MS_CYCLES)
  ) u_tick (
    .clk(CLK),
    .rst(SYS_RST),
    .restart(fail_event),
    .ms_tick(ms_tick),
    .sec_tick(sec_tick)
  );

  // ************************************************************
  // Power sequence: interrupt and hold lines
  // ************************************************************
  logic [10:0] seq_ms; // Milliseconds within the current state
  ost_pkg::ost_seq_t next_seq;
  logic [10:0] next_seq_ms;
  logic next_int_n;
  logic next_hold_n;

  // Next sequence values
  always_comb begin
    next_seq = seq;
    next_seq_ms = seq_ms;
    next_int_n = PFAIL_INT_N;
    next_hold_n = RESTART_HOLD_N;
    unique case (seq)
      ost_pkg::SEQ_RUN: begin
        if (!pwr_ok) begin
          next_seq = ost_pkg::SEQ_FAIL;
          next_seq_ms = '0;
          next_int_n = 1'b0;
        end
      end
      ost_pkg::SEQ_FAIL: begin
        if (ms_tick && (seq_ms == ost_pkg::HOLD_DELAY_MS - 11'h001)) begin
          next_seq = ost_pkg::SEQ_HOLD;
          next_seq_ms = '0;
          next_hold_n = 1'b0;
          next_int_n = 1'b1;
        end else if (ms_tick) begin
          next_seq_ms = seq_ms + 11'h001;
        end
      end
      ost_pkg::SEQ_HOLD: begin
        // Wait for the supply to return
        if (pwr_ok) begin
          next_seq = ost_pkg::SEQ_RESTORE;
          next_seq_ms = '0;
        end
      end
      ost_pkg::SEQ_RESTORE: begin
        if (!pwr_ok) begin
          next_seq = ost_pkg::SEQ_HOLD;
          next_seq_ms = '0;
        end else if (ms_tick && (seq_ms == ost_pkg::RESTORE_HOLD_MS - 11'h001)) begin
          next_seq = ost_pkg::SEQ_RUN;
          next_hold_n = 1'b1;
        end else if (ms_tick) begin
          next_seq_ms = seq_ms + 11'h001;
        end
      end
    endcase
  end

  // Register the sequence
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      seq <= ost_pkg::SEQ_RUN;
      seq_ms <= '0;
      PFAIL_INT_N <= 1'b1;
      RESTART_HOLD_N <= 1'b1;
    end else begin
      seq <= next_seq;
      seq_ms <= next_seq_ms;
      PFAIL_INT_N <= next_int_n;
      RESTART_HOLD_N <= next_hold_n;
    end
  end

  // ************************************************************
  // Downtime accumulator
  // ************************************************************
  // separate count registers
  ost_pkg::ost_dta_t downtime_accumulator; // Minutes, seconds and saturation
  ost_pkg::ost_dta_t next_dta;
  logic sw_clr; // Software clear pulse
  logic counting; // Outage in progress

  assign counting = (seq != ost_pkg::SEQ_RUN);

  // Next accumulator values
  always_comb begin
    next_dta = downtime_accumulator;
    if (sw_clr && !counting) begin
      // clean state for the next outage
      next_dta = '0;
    end else if (counting && sec_tick && !downtime_accumulator.sat) begin
      if (downtime_accumulator.seconds == ost_pkg::SEC_LAST) begin
        next_dta.seconds = 8'h00;
        next_dta.minutes = downtime_accumulator.minutes + 8'h01;
        if (downtime_accumulator.minutes == ost_pkg::MIN_LAST - 8'h01) begin
          next_dta.sat = 1'b1;
        end
      end else begin
        next_dta.seconds = downtime_accumulator.seconds + 8'h01;
      end
    end
  end

  // Register the accumulator
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      downtime_accumulator <= '0;
    end else begin
      downtime_accumulator <= next_dta;
    end
  end

  // ************************************************************
  // Restart timer
  // ************************************************************
  ost_pkg::ost_rt_t rt; // Restart timer state
  logic [10:0] rt_ms; // Milliseconds timed
  ost_pkg::ost_rt_t next_rt;
  logic [10:0] next_rt_ms;
  logic next_rt_out;

  // Next restart timer values
  always_comb begin
    next_rt = rt;
    next_rt_ms = rt_ms;
    next_rt_out = RESTART_OUT;
    unique case (rt)
      ost_pkg::RT_ARMED: begin
        next_rt_out = 1'b1;
        if (pwr_ok) begin
          next_rt_ms = '0;
        end else if (counting && ms_tick) begin
          if (rt_ms == ost_pkg::RT_TIMEOUT_MS - 11'h001) begin
            next_rt = ost_pkg::RT_LOW;
            next_rt_ms = '0;
            next_rt_out = 1'b0;
          end else begin
            next_rt_ms = rt_ms + 11'h001;
          end
        end
      end
      ost_pkg::RT_LOW: begin
        // Hold the output low until the hold line rises
        if (RESTART_HOLD_N && !counting) begin
          next_rt = ost_pkg::RT_RELEASE;
          next_rt_ms = '0;
        end
      end
      ost_pkg::RT_RELEASE: begin
        if (counting) begin
          next_rt = ost_pkg::RT_LOW;
        end else if (ms_tick && (rt_ms == ost_pkg::RT_RELEASE_MS - 11'h001)) begin
          next_rt = ost_pkg::RT_ARMED;
          next_rt_ms = '0;
          next_rt_out = 1'b1;
        end else if (ms_tick) begin
          next_rt_ms = rt_ms + 11'h001;
        end
      end
      default: begin
        // Recover from an illegal code
        next_rt = ost_pkg::RT_ARMED;
        next_rt_ms = '0;
        next_rt_out = 1'b1;
      end
    endcase
  end

  // Register the restart timer
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rt <= ost_pkg::RT_ARMED;
      rt_ms <= '0;
      RESTART_OUT <= 1'b1;
    end else begin
      rt <= next_rt;
      rt_ms <= next_rt_ms;
      RESTART_OUT <= next_rt_out;
    end
  end

  // ************************************************************
  // Bus slave and interrupt registers
  // ************************************************************
  ost_pkg::ost_ahb_req_t req; // Pending data phase
  ost_pkg::ost_ahb_req_t next_req;
  logic [ost_pkg::IRQ_W-1:0] irq_stat; // Sticky events
  logic [ost_pkg::IRQ_W-1:0] irq_en; // Event enables
  logic [ost_pkg::IRQ_W-1:0] next_irq_stat;
  logic [ost_pkg::IRQ_W-1:0] next_irq_en;
  logic [ost_pkg::IRQ_W-1:0] events;
  logic [ost_pkg::IRQ_W-1:0] irq_clr;
  logic [31:0] next_rdata;
  logic wr_ok; // Write data phase this cycle

  assign wr_ok = req.valid && req.write;
  assign sw_clr = wr_ok && (req.addr == ost_pkg::ADDR_CONTROL) && HWDATA[ost_pkg::CTRL_CLR_BIT];

  // Address phase capture, read data and register updates
  always_comb begin
    next_req.valid = HSEL && HTRANS[1] && HREADY && (HSIZE == ost_pkg::HSIZE_WORD)
      && (HADDR[31:8] == 24'h000000);
    next_req.write = HWRITE;
    next_req.addr = HADDR[7:0];
    next_rdata = 32'h00000000;
    if (next_req.valid && !HWRITE) begin
      // Unmapped and write-only offsets read as zero
      unique case (HADDR[7:0])
        ost_pkg::ADDR_COUNT: begin
          next_rdata[ost_pkg::CNT_MIN_LSB +: 8] = downtime_accumulator.minutes;
          next_rdata[ost_pkg::CNT_SEC_LSB +: 8] = downtime_accumulator.seconds;
        end
        ost_pkg::ADDR_STATUS: begin
          next_rdata[ost_pkg::STAT_PWR_BIT] = pwr_ok;
          next_rdata[ost_pkg::STAT_HOLD_BIT] = RESTART_HOLD_N;
          next_rdata[ost_pkg::STAT_RT_BIT] = RESTART_OUT;
          next_rdata[ost_pkg::STAT_SAT_BIT] = downtime_accumulator.sat;
        end
        ost_pkg::ADDR_IRQ_STAT: begin
          next_rdata[ost_pkg::IRQ_W-1:0] = irq_stat;
        end
        ost_pkg::ADDR_IRQ_EN: begin
          next_rdata[ost_pkg::IRQ_W-1:0] = irq_en;
        end
        default: begin
          next_rdata = 32'h00000000;
        end
      endcase
    end
    // Events of this cycle
    events[ost_pkg::IRQ_FAIL_BIT] = fail_event;
    events[ost_pkg::IRQ_RESTORE_BIT] = !RESTART_HOLD_N && next_hold_n;
    events[ost_pkg::IRQ_SAT_BIT] = !downtime_accumulator.sat && next_dta.sat;
    events[ost_pkg::IRQ_RT_BIT] = RESTART_OUT && !next_rt_out;
    irq_clr = '0;
    next_irq_en = irq_en;
    if (wr_ok && (req.addr == ost_pkg::ADDR_IRQ_CLR)) begin
      irq_clr = HWDATA[ost_pkg::IRQ_W-1:0];
    end
    if (wr_ok && (req.addr == ost_pkg::ADDR_IRQ_EN)) begin
      next_irq_en = HWDATA[ost_pkg::IRQ_W-1:0];
    end
    // A new event wins over a clear in the same cycle
    next_irq_stat = (irq_stat & ~irq_clr) | events;
  end

  // Register bus state and interrupt output
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      req <= '0;
      irq_stat <= '0;
      irq_en <= ost_pkg::IRQ_EN_RESET;
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      req <= next_req;
      irq_stat <= next_irq_stat;
      irq_en <= next_irq_en;
      HRDATA <= next_rdata;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      IRQ <= |(next_irq_stat & next_irq_en);
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_int_fall;
    @(posedge CLK) disable iff (SYS_RST)
    (seq == ost_pkg::SEQ_RUN && !pwr_ok) |=> !PFAIL_INT_N;
  endproperty
  a_int_fall: assert property (p_int_fall) else $error("interrupt did not fall");

  property p_int_held;
    @(posedge CLK) disable iff (SYS_RST)
    $rose(PFAIL_INT_N) |-> $fell(RESTART_HOLD_N);
  endproperty
  a_int_held: assert property (p_int_held) else $error("interrupt released early");

  property p_hold_delay;
    @(posedge CLK) disable iff (SYS_RST)
    $fell(RESTART_HOLD_N) |-> ($past(seq_ms) == ost_pkg::HOLD_DELAY_MS - 11'h001)
      && $past(ms_tick) && !PFAIL_INT_N == 1'b0;
  endproperty
  a_hold_delay: assert property (p_hold_delay) else $error("hold fell at wrong time");

  property p_hold_release;
    @(posedge CLK) disable iff (SYS_RST)
    $rose(RESTART_HOLD_N) |-> ($past(seq_ms) == ost_pkg::RESTORE_HOLD_MS - 11'h001)
      && $past(pwr_ok);
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("hold rose at wrong time");

  property p_sec_range;
    @(posedge CLK) disable iff (SYS_RST)
    downtime_accumulator.seconds <= ost_pkg::SEC_LAST;
  endproperty
  a_sec_range: assert property (p_sec_range) else $error("seconds out of range");

  property p_carry;
    @(posedge CLK) disable iff (SYS_RST)
    (counting && sec_tick && !downtime_accumulator.sat && downtime_accumulator.seconds == ost_pkg::SEC_LAST)
      |=> (downtime_accumulator.seconds == 8'h00) && (downtime_accumulator.minutes == $past(downtime_accumulator.minutes) + 8'h01);
  endproperty
  a_carry: assert property (p_carry) else $error("minute carry wrong");

  property p_saturate;
    @(posedge CLK) disable iff (SYS_RST)
    (downtime_accumulator.minutes == ost_pkg::MIN_LAST) |-> downtime_accumulator.sat ##1 (downtime_accumulator.sat || $past(sw_clr));
  endproperty
  a_saturate: assert property (p_saturate) else $error("saturation flag missing");

  property p_latched;
    @(posedge CLK) disable iff (SYS_RST)
    (downtime_accumulator.sat && !sw_clr) |=> $stable(downtime_accumulator.minutes) && $stable(downtime_accumulator.seconds) && downtime_accumulator.sat;
  endproperty
  a_latched: assert property (p_latched) else $error("saturated count moved");

  property p_rt_timeout;
    @(posedge CLK) disable iff (SYS_RST)
    $fell(RESTART_OUT) |-> ($past(rt_ms) == ost_pkg::RT_TIMEOUT_MS - 11'h001)
      && !RESTART_HOLD_N;
  endproperty
  a_rt_timeout: assert property (p_rt_timeout) else $error("restart fell at wrong time");

  property p_rt_release;
    @(posedge CLK) disable iff (SYS_RST)
    $rose(RESTART_OUT) |-> ($past(rt_ms) == ost_pkg::RT_RELEASE_MS - 11'h001)
      && RESTART_HOLD_N;
  endproperty
  a_rt_release: assert property (p_rt_release) else $error("restart rose at wrong time");

  property p_rt_early;
    @(posedge CLK) disable iff (SYS_RST)
    (rt == ost_pkg::RT_ARMED && pwr_ok) |=> (rt_ms == 11'h000) && RESTART_OUT;
  endproperty
  a_rt_early: assert property (p_rt_early) else $error("early restore not cleared");

endmodule

`default_nettype wire

// ===== ost_pkg.sv
// Notes on behaviour
// - Count from power failure until hold rises
// - Separate eight-bit minutes and seconds counts
// - Seconds step 0 to 59, once a second
// - Sixtieth second bumps minutes, clears seconds
// - Minutes at 255 set flag bit 7, stop
// - Saturated minutes held until software clear
// - Outage time within one second
// - Restart output rests high without long outage
// - Restart timing starts when interrupt falls
// - Outage of 1.75 s drives restart output low
// - Low until 50 ms after hold rises
// - Early restoration keeps high, clears count
// - Interrupt falls at once, held until hold falls
// - Hold falls 3 ms after interrupt falls
// - Hold stays low 150 ms after restoration
`default_nettype none

package ost_pkg;

  // ************************************************************
  // Time base
  // ************************************************************
  // Clock period in picoseconds (40 MHz)
  localparam int CLK_PERIOD_PS = 25000;
  // One millisecond in picoseconds
  localparam int MS_PS = 1000000000;
  // Clock cycles per millisecond tick
  localparam int MS_CYCLES = MS_PS / CLK_PERIOD_PS;
  // Width of the millisecond prescaler
  localparam int MS_CNT_W = 16;
  // Milliseconds per second tick
  localparam logic [9:0] SEC_MS = 10'h3e8;

  // ************************************************************
  // Sequence times, in milliseconds (one tick each)
  // ************************************************************
  // Interrupt fall to hold fall
  localparam logic [10:0] HOLD_DELAY_MS = 11'h003;
  // Restoration to hold rise
  localparam logic [10:0] RESTORE_HOLD_MS = 11'h096;
  // Outage length that trips the restart timer
  localparam logic [10:0] RT_TIMEOUT_MS = 11'h6d6;
  // Restart output low time after hold rises
  localparam logic [10:0] RT_RELEASE_MS = 11'h032;

  // ************************************************************
  // Accumulator limits
  // ************************************************************
  localparam logic [7:0] SEC_LAST = 8'h3b;
  localparam logic [7:0] MIN_LAST = 8'hff;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] ADDR_COUNT = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h14;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  // Status register bits
  localparam int STAT_PWR_BIT = 0;
  localparam int STAT_HOLD_BIT = 1;
  localparam int STAT_RT_BIT = 2;
  localparam int STAT_SAT_BIT = 7;
  // Count register fields
  localparam int CNT_SEC_LSB = 0;
  localparam int CNT_MIN_LSB = 8;
  // Control register bits
  localparam int CTRL_CLR_BIT = 0;
  // Interrupt event bits
  localparam int IRQ_FAIL_BIT = 0;
  localparam int IRQ_RESTORE_BIT = 1;
  localparam int IRQ_SAT_BIT = 2;
  localparam int IRQ_RT_BIT = 3;
  localparam int IRQ_W = 4;
  localparam logic [3:0] IRQ_EN_RESET = 4'h0;
  // Bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ************************************************************
  // Types
  // ************************************************************
  // Power sequence states
  typedef enum logic [1:0] {SEQ_RUN, SEQ_FAIL, SEQ_HOLD, SEQ_RESTORE} ost_seq_t;
  // Restart timer states
  typedef enum logic [1:0] {RT_ARMED, RT_LOW, RT_RELEASE} ost_rt_t;
  // Captured bus address phase
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic valid;
  } ost_ahb_req_t;
  // Accumulator contents
  typedef struct packed {
    logic [7:0] minutes;
    logic [7:0] seconds;
    logic sat;
  } ost_dta_t;

endpackage

`default_nettype wire

// ===== ost_supply_model.sv
`timescale 1ns/100ps
`default_nettype none

// ************************************************************
// Supply sense model
// ************************************************************
module ost_supply_model (
  // Clock
  input wire logic clk,
  // Outage command from the bench
  input wire logic fail,
  // Sense pin, high while supply is good
  output logic pwr_good
);
  // Sense pin follows the outage command one edge later; the bench holds
  // the command low through reset, so the supply reads good from the first edge
  always_ff @(posedge clk) begin
    pwr_good <= ~fail;
  end
endmodule

`default_nettype wire

// ===== ost_tick_gen.sv
`timescale 1ns/100ps
`default_nettype none

module ost_tick_gen #(
  parameter int MS_CYCLES = ost_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Phase restart
  input wire logic restart,
  // Tick outputs
  output logic ms_tick,
  output logic sec_tick
);

  // ************************************************************
  // Prescaler state
  // ************************************************************
  logic [ost_pkg::MS_CNT_W-1:0] cyc_cnt; // Cycles within the millisecond
  logic [9:0] ms_cnt; // Milliseconds within the second
  logic [ost_pkg::MS_CNT_W-1:0] next_cyc_cnt;
  logic [9:0] next_ms_cnt;
  logic next_ms_tick;
  logic next_sec_tick;
  logic [ost_pkg::MS_CNT_W-1:0] cyc_last; // Terminal cycle count

  assign cyc_last = ost_pkg::MS_CNT_W'(MS_CYCLES - 1);

  // Next prescaler values; restart aligns both ticks to the event
  // exact cycle counting
  always_comb begin
    next_cyc_cnt = cyc_cnt + 1'b1;
    next_ms_cnt = ms_cnt;
    next_ms_tick = 1'b0;
    next_sec_tick = 1'b0;
    if (restart) begin
      // Fresh phase from the restart cycle
      next_cyc_cnt = '0;
      next_ms_cnt = '0;
    end else if (cyc_cnt == cyc_last) begin
      // Millisecond boundary
      next_cyc_cnt = '0;
      next_ms_tick = 1'b1;
      if (ms_cnt == ost_pkg::SEC_MS - 10'h001) begin
        next_ms_cnt = '0;
        next_sec_tick = 1'b1;
      end else begin
        next_ms_cnt = ms_cnt + 10'h001;
      end
    end
  end

  // Register the prescaler
  always_ff @(posedge clk) begin
    if (rst) begin
      cyc_cnt <= '0;
      ms_cnt <= '0;
      ms_tick <= 1'b0;
      sec_tick <= 1'b0;
    end else begin
      cyc_cnt <= next_cyc_cnt;
      ms_cnt <= next_ms_cnt;
      ms_tick <= next_ms_tick;
      sec_tick <= next_sec_tick;
    end
  end

endmodule

`default_nettype wire

// ===== tb_outage_timing_unit.sv
`timescale 1ns/100ps
`default_nettype none

module tb_outage_timing_unit;
  // ************************************************************
  // Bench signals
  // ************************************************************
  logic clk, rst, fail, pg, hsel, hwrite, hready, hresp;
  logic int_n, hold_n, rt, irq;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  int n_mismatch = 0;
  int comparisons = 0;

  // Design with one clock per millisecond tick
  ost_outage_timing_unit #(.MS_CYCLES(1)) dut (
    .CLK(clk), .SYS_RST(rst), .PWR_GOOD(pg),
    .PFAIL_INT_N(int_n), .RESTART_HOLD_N(hold_n), .RESTART_OUT(rt), .IRQ(irq),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(ost_pkg::HSIZE_WORD), .HWDATA(hwdata), .HREADY(hready),
    .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata)
  );

  // Supply sense partner
  ost_supply_model sup (.clk(clk), .fail(fail), .pwr_good(pg));

  // Clock generator, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  // Report verdict and stop
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Exact compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Cycle count inside a window
  task automatic rng(input int v, input int lo, input int hi);
    comparisons++;
    if (v < lo || v > hi) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask

  // One single AHB transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    // Address phase holds until ready is seen; only the watchdog ends a hang
    while (hready !== 1'b1) begin
      @(posedge clk);
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) begin
      @(posedge clk);
    end
    q = hrdata;
  endtask

  // Register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // Register read and compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  // Selected power line
  function automatic logic line(input int s);
    case (s)
      0: return int_n;
      1: return hold_n;
      default: return rt;
    endcase
  endfunction

  // Bounded wait for a line level, counting cycles
  task automatic wait_lvl(input int s, input logic v, output int n);
    n = 0;
    while (line(s) !== v && n < 5000) begin
      @(posedge clk);
      n++;
    end
    // A wait that runs out is a mismatch
    if (n >= 5000) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, line(s), v);
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  // Reset values and an unmapped read
  task automatic t_reset;
    rdc(ost_pkg::ADDR_STATUS, 32'h7);
    rdc(ost_pkg::ADDR_COUNT, 32'h0);
    rdc(ost_pkg::ADDR_IRQ_EN, 32'h0);
    rdc(8'h18, 32'h0);
    chk({irq, rt}, 2'b01);
    chk(hresp, 1'b0);
  endtask

  // Short outage, interrupt mask and clear
  task automatic t_short;
    int n;
    wr(ost_pkg::ADDR_IRQ_EN, 32'hf);
    fail <= 1'b1;
    wait_lvl(0, 1'b0, n);
    wait_lvl(1, 1'b0, n);
    rng(n, 1, 5);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wr(ost_pkg::ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wr(ost_pkg::ADDR_IRQ_EN, 32'hf);
    wr(ost_pkg::ADDR_IRQ_CLR, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    repeat (400) @(posedge clk);
    fail <= 1'b0;
    wait_lvl(1, 1'b1, n);
    rng(n, 145, 160);
    chk(rt, 1'b1);
    rdc(ost_pkg::ADDR_COUNT, 32'h0);
    rdc(ost_pkg::ADDR_IRQ_STAT, 32'h2);
    wr(ost_pkg::ADDR_IRQ_CLR, 32'hf);
  endtask

  // Long outage past one minute, restart timer, software clear
  task automatic t_long;
    int n;
    fail <= 1'b1;
    wait_lvl(0, 1'b0, n);
    wait_lvl(2, 1'b0, n);
    rng(n, 1500, 2000);
    repeat (59750) @(posedge clk);
    fail <= 1'b0;
    wait_lvl(1, 1'b1, n);
    chk(rt, 1'b0);
    wait_lvl(2, 1'b1, n);
    rng(n, 26, 74);
    rdc(ost_pkg::ADDR_COUNT, 32'h101);
    rdc(ost_pkg::ADDR_STATUS, 32'h7);
    rdc(ost_pkg::ADDR_IRQ_STAT, 32'hb);
    wr(ost_pkg::ADDR_CONTROL, 32'h1);
    rdc(ost_pkg::ADDR_COUNT, 32'h0);
    wr(ost_pkg::ADDR_IRQ_CLR, 32'hf);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
  endtask

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  // Reset for 16 cycles, then run every scenario
  initial begin
    rst = 1'b1;
    fail = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_short;
    t_long;
    wrap_up;
  end

  // Cut a hang short well beyond the expected run
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    wrap_up;
  end
endmodule

`default_nettype wire
